// ---- core/dirb_pkg.sv ----
// Package for the drive info response builder: codes, layout constants and carriers.
package dirb_pkg;

	// ****************************************
	// Control codes and command identifiers
	// ****************************************
	localparam logic [7:0] CODE_CONFIG = 8'h41;
	localparam logic [7:0] CODE_FORMAT = 8'h42;
	localparam logic [7:0] CODE_DRVINFO = 8'h43;
	localparam logic [7:0] CODE_STATUS = 8'h44;
	localparam logic [7:0] CODE_DIAG = 8'h49;
	localparam logic [7:0] LDSI_GATE_ID = 8'h01;

	// ****************************************
	// Response layout
	// ****************************************
	localparam int CFG_LEN = 74;
	localparam logic [15:0] CFG_COUNT = 16'h0048;
	localparam int FMT_LEN = 16;
	localparam int DSI_LEN = 8;
	localparam int DIAG_LEN = 30;
	localparam int STAT_LEN = 8;
	localparam logic [7:0] DEV_CLASS_DISK = 8'h01;
	localparam logic [15:0] SECT_NOT_FIXED = 16'hffff;
	localparam logic [7:0] OFS_LAST_CYL = 8'h06;
	localparam logic [7:0] OFS_SYNC = 8'h48;
	localparam logic [7:0] OFS_GATE = 8'h49;

	// ****************************************
	// Reset values of the alterable fields
	// ****************************************
	localparam logic [7:0] SYNC_RESET = 8'h5a;
	localparam logic [7:0] GATE_RESET = 8'h08;

	// Response selector.
	typedef enum logic [2:0] {
		RSP_CONFIG = 3'b000,
		RSP_FORMAT = 3'b001,
		RSP_DRVINFO = 3'b010,
		RSP_DIAG = 3'b011,
		RSP_STATUS = 3'b100
	} dirb_rsp_e;

	// Builder state.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b10
	} dirb_state_e;

	// Drive geometry and timing, fixed per drive.
	typedef struct packed {
		logic [7:0] drive_type;
		logic [7:0] capability;
		logic [7:0] feature;
		logic [31:0] last_cyl;
		logic [31:0] defect_cyl;
		logic [15:0] heads;
		logic [15:0] sectors;
		logic fixed_sectored;
		logic [31:0] octets_track;
		logic [31:0] seek_single;
		logic [31:0] seek_avg;
		logic [31:0] seek_max;
		logic [31:0] rotation;
		logic [31:0] head_switch;
		logic [31:0] wr_recovery;
		logic [31:0] maker;
		logic [63:0] model;
		logic [31:0] revision;
		logic [63:0] card_serial;
		logic [15:0] switches;
	} dirb_cfg_s;

	// Eight status octets, octet 0 in the top byte.
	typedef struct packed {
		logic [7:0] general;
		logic [7:0] unsolicited;
		logic [7:0] bus_ctl;
		logic [39:0] drive;
	} dirb_stat_s;

endpackage

// ---- core/dirb_status_hold.sv ----
// Sticky exception status store with clear on successful read.
`timescale 1ns/10ps
module dirb_status_hold (
	input wire logic CLK_I, // Clock.
	input wire logic SYS_RST_I, // Reset.
	input wire dirb_pkg::dirb_stat_s set_i, // Exception events.
	input wire logic clear_i, // Clear after successful read.
	output dirb_pkg::dirb_stat_s stat_o // Held status.
);
	import dirb_pkg::*;

	dirb_stat_s stat_reg;

	// New events win over a clear in the same cycle.
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			stat_reg <= '0;
		end else if (clear_i) begin
			stat_reg <= set_i;
		end else begin
			stat_reg <= stat_reg | set_i;
		end
	end

	assign stat_o = stat_reg;

	a_clear_keeps_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		clear_i |=> stat_reg == $past(set_i)) else $error("clear lost an event");

endmodule // dirb_status_hold

// ---- core/dirb_core.sv ----
// Drive info response builder: configuration, format, drive info, diagnostic and status responses.
`timescale 1ns/10ps
module dirb_core (
	input wire logic CLK_I, // Clock, 100 MHz.
	input wire logic SYS_RST_I, // Synchronous reset, active high.
	input wire dirb_pkg::dirb_cfg_s CFG_I, // Fixed drive parameters.
	input wire logic CTL_VALID_I, // Control code strobe.
	input wire logic [7:0] CTL_CODE_I, // Control code.
	input wire logic UID_LOAD_I, // Load unique identifier strobe.
	input wire logic [63:0] UID_I, // New unique identifier.
	input wire logic SYNC_LOAD_I, // Modify sync octet strobe.
	input wire logic [7:0] SYNC_I, // New sync octet.
	input wire logic LDSI_LOAD_I, // Load drive specific info strobe.
	input wire logic [7:0] LDSI_ID_I, // Its command identifier.
	input wire logic [7:0] LDSI_VAL_I, // Its value.
	input wire logic [8*dirb_pkg::FMT_LEN-1:0] FMT_I, // Format spec from octet 2 up.
	input wire logic [8*dirb_pkg::DSI_LEN-1:0] DSI_I, // Drive specific info octets.
	input wire logic [8*dirb_pkg::DIAG_LEN-17:0] DIAG_I, // Diagnostic octets 2 to 29.
	input wire dirb_pkg::dirb_stat_s STAT_SET_I, // Exception events.
	input wire logic OUT_READY_I, // Controller takes octet.
	input wire logic CMPL_VALID_I, // Controller completion status strobe.
	input wire logic CMPL_OK_I, // Completion status shows success.
	output logic OUT_VALID_O, // Octet valid.
	output logic [7:0] OUT_DATA_O, // Response octet.
	output logic OUT_LAST_O, // Final octet of response.
	output logic REJECT_O, // Control code rejected pulse.
	output logic [7:0] SYNC_O, // Current sync octet.
	output logic [7:0] GATE_O // Current read gate delay.
);
	import dirb_pkg::*;

	// ****************************************
	// State
	// ****************************************
	dirb_state_e state_reg;
	dirb_rsp_e rsp_reg;
	logic [7:0] idx_reg;
	logic [7:0] len_reg;
	logic [63:0] uid_reg;
	logic [7:0] sync_reg;
	logic [7:0] gate_reg;
	logic valid_reg;
	logic [7:0] data_reg;
	logic last_reg;
	logic reject_reg;
	logic clear_pulse;
	dirb_stat_s stat_now;
	logic [8*CFG_LEN-1:0] cfg_img;
	logic [7:0] oct_next;
	logic last_next;

	// Most significant octet first at increasing positions.
	function automatic logic [7:0] pick(input logic [8*CFG_LEN-1:0] img, input logic [7:0] i,
		input int n);
		pick = img[8*(n-1-int'(i)) +: 8];
	endfunction

	// Status zero from octet i onward.
	function automatic logic rest_zero(input dirb_stat_s s, input logic [7:0] i);
		logic [63:0] v;
		v = s;
		rest_zero = ((v << (8 * i)) == 64'h0);
	endfunction

	// ****************************************
	// Status store
	// ****************************************
	dirb_status_hold u_stat (
		.CLK_I(CLK_I),
		.SYS_RST_I(SYS_RST_I),
		.set_i(STAT_SET_I),
		.clear_i(clear_pulse),
		.stat_o(stat_now)
	);

	// Clear only on successful completion after a status read.
	assign clear_pulse = (state_reg == ST_WAIT) && CMPL_VALID_I && CMPL_OK_I;

	// Configuration image, octet 0 at the top.
	assign cfg_img = {CFG_COUNT,
		DEV_CLASS_DISK,
		CFG_I.drive_type, CFG_I.capability,
		CFG_I.feature,
		CFG_I.last_cyl,
		CFG_I.defect_cyl, CFG_I.heads,
		(CFG_I.fixed_sectored ? CFG_I.sectors : SECT_NOT_FIXED),
		CFG_I.octets_track,
		CFG_I.seek_single,
		CFG_I.seek_avg,
		CFG_I.seek_max,
		CFG_I.rotation,
		CFG_I.head_switch,
		CFG_I.wr_recovery,
		CFG_I.maker, CFG_I.model, CFG_I.revision,
		uid_reg,
		CFG_I.switches,
		sync_reg,
		gate_reg};

	// Octet chooser for the active response.
	always_comb begin
		oct_next = 8'h00;
		last_next = 1'b0;
		case (rsp_reg)
			RSP_CONFIG: begin
				oct_next = pick(cfg_img, idx_reg, CFG_LEN);
				last_next = (idx_reg == 8'(CFG_LEN - 1));
			end
			RSP_FORMAT: begin
				if (idx_reg < 8'h02) begin
					// Octets 2 to n follow the count, so the count is n-1.
					oct_next = (idx_reg == 8'h00) ? 8'h00 : 8'(FMT_LEN);
				end else begin
					oct_next = pick({FMT_I, {(8*(CFG_LEN-FMT_LEN)){1'b0}}},
						8'(idx_reg - 8'h02), CFG_LEN);
				end
				last_next = (idx_reg == 8'(FMT_LEN + 1));
			end
			RSP_DRVINFO: begin
				if (idx_reg < 8'h02) begin
					oct_next = (idx_reg == 8'h00) ? 8'h00 : 8'(DSI_LEN);
				end else begin
					oct_next = pick({DSI_I, {(8*(CFG_LEN-DSI_LEN)){1'b0}}},
						8'(idx_reg - 8'h02), CFG_LEN);
				end
				last_next = (idx_reg == 8'(DSI_LEN + 1));
			end
			RSP_DIAG: begin
				if (idx_reg < 8'h02) begin
					oct_next = (idx_reg == 8'h00) ? 8'h00 : 8'(DIAG_LEN - 2);
				end else begin
					oct_next = pick({DIAG_I, {(8*(CFG_LEN-DIAG_LEN+2)){1'b0}}},
						8'(idx_reg - 8'h02), CFG_LEN);
				end
				last_next = (idx_reg == 8'(DIAG_LEN - 1));
			end
			RSP_STATUS: begin
				oct_next = pick({stat_now, {(8*(CFG_LEN-STAT_LEN)){1'b0}}}, idx_reg,
					CFG_LEN);
				last_next = (idx_reg == 8'(STAT_LEN - 1)) ||
					rest_zero(stat_now, 8'(idx_reg + 8'h01));
			end
			default: begin
				oct_next = 8'h00;
				last_next = 1'b1;
			end
		endcase
	end

	// ****************************************
	// Response sequencer
	// ****************************************
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			state_reg <= ST_IDLE;
			rsp_reg <= RSP_CONFIG;
			idx_reg <= 8'h00;
			valid_reg <= 1'b0;
			data_reg <= 8'h00;
			last_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			reject_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (CTL_VALID_I) begin
						idx_reg <= 8'h00;
						if (CTL_CODE_I == CODE_CONFIG) begin
							rsp_reg <= RSP_CONFIG;
							state_reg <= ST_SEND;
						end else if (CTL_CODE_I == CODE_FORMAT) begin
							rsp_reg <= RSP_FORMAT;
							state_reg <= ST_SEND;
						end else if (CTL_CODE_I == CODE_DRVINFO) begin
							rsp_reg <= RSP_DRVINFO;
							state_reg <= ST_SEND;
						end else if (CTL_CODE_I == CODE_STATUS) begin
							rsp_reg <= RSP_STATUS;
							state_reg <= ST_SEND;
						end else if (CTL_CODE_I == CODE_DIAG) begin
							rsp_reg <= RSP_DIAG;
							state_reg <= ST_SEND;
						end else begin
							reject_reg <= 1'b1;
						end
					end
				end
				ST_SEND: begin
					if (!valid_reg || OUT_READY_I) begin
						if (valid_reg && last_reg) begin
							valid_reg <= 1'b0;
							state_reg <= (rsp_reg == RSP_STATUS) ? ST_WAIT : ST_IDLE;
						end else begin
							valid_reg <= 1'b1;
							data_reg <= oct_next;
							last_reg <= last_next;
							idx_reg <= 8'(idx_reg + 8'h01);
						end
					end
				end
				ST_WAIT: begin
					if (CMPL_VALID_I) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Alterable identifier, sync octet and gate delay.
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			uid_reg <= 64'h0;
			sync_reg <= SYNC_RESET;
			gate_reg <= GATE_RESET;
		end else begin
			if (UID_LOAD_I) begin
				uid_reg <= UID_I;
			end else if (uid_reg == 64'h0) begin
				uid_reg <= CFG_I.card_serial;
			end
			if (SYNC_LOAD_I) begin
				sync_reg <= SYNC_I;
			end
			if (LDSI_LOAD_I && LDSI_ID_I == LDSI_GATE_ID) begin
				gate_reg <= LDSI_VAL_I;
			end
		end
	end

	assign OUT_VALID_O = valid_reg;
	assign OUT_DATA_O = data_reg;
	assign OUT_LAST_O = last_reg;
	assign REJECT_O = reject_reg;
	assign SYNC_O = sync_reg;
	assign GATE_O = gate_reg;

	// ****************************************
	// Checks
	// ****************************************
	a_reject_no_data: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		REJECT_O |-> !OUT_VALID_O && state_reg == ST_IDLE) else $error("reject sent data");
	a_sync_update: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		SYNC_LOAD_I |=> SYNC_O == $past(SYNC_I)) else $error("sync not loaded");
	a_gate_update: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		LDSI_LOAD_I && LDSI_ID_I == LDSI_GATE_ID |=> GATE_O == $past(LDSI_VAL_I))
		else $error("gate not loaded");
	a_cfg_count: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		state_reg == ST_SEND && rsp_reg == RSP_CONFIG && idx_reg == 8'h01 && valid_reg
		|-> OUT_DATA_O == 8'h00) else $error("count high octet wrong");
	a_status_bound: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		rsp_reg == RSP_STATUS && valid_reg |-> idx_reg <= 8'(STAT_LEN))
		else $error("status too long");
	// A failed completion after a status read must leave every held bit in place.
	a_clear_only_ok: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		state_reg == ST_WAIT && CMPL_VALID_I && !CMPL_OK_I
		|=> stat_now == ($past(stat_now) | $past(STAT_SET_I))) else $error("bad clear");
	a_last_drops: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		OUT_VALID_O && OUT_LAST_O && OUT_READY_I |=> !OUT_VALID_O)
		else $error("valid after last");
	a_sects_ones: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
		!CFG_I.fixed_sectored |-> cfg_img[8*(CFG_LEN-18)+15 -: 16] == SECT_NOT_FIXED)
		else $error("sectors not all ones");
	c_status_read: cover property (@(posedge CLK_I) clear_pulse);
	c_reject: cover property (@(posedge CLK_I) REJECT_O);
	c_cfg_done: cover property (@(posedge CLK_I)
		rsp_reg == RSP_CONFIG && OUT_LAST_O && OUT_READY_I);
	// Status read that ends before the eighth octet.
	c_status_early: cover property (@(posedge CLK_I)
		rsp_reg == RSP_STATUS && OUT_VALID_O && OUT_LAST_O && idx_reg < 8'(STAT_LEN));

endmodule // dirb_core

// ---- sim/dirb_ctl_model.sv ----
// Disk controller model that takes response octets with a variable stall.
`timescale 1ns/10ps
module dirb_ctl_model (
	input wire logic CLK_I, // Clock.
	input wire logic slow_i, // Stall most cycles when high.
	input wire logic valid_i, // Octet valid from the builder.
	input wire logic [7:0] data_i, // Octet from the builder.
	input wire logic last_i, // Final octet flag.
	output logic ready_o // Octet taken.
);
	// Octets taken so far, final flag in the top bit.
	logic [8:0] rx_q[$];

	initial ready_o = 1'b0;

	// Take an octet when both sides agree, then choose the next ready level.
	always @(posedge CLK_I) begin
		if (valid_i && ready_o) begin
			rx_q.push_back({last_i, data_i});
		end
		ready_o <= slow_i ? ($urandom_range(3) == 0) : ($urandom_range(3) != 0);
	end
endmodule // dirb_ctl_model

// ---- sim/drive_info_response_builder_tb.sv ----
// Self-checking bench for the drive info response builder.
`timescale 1ns/10ps
module drive_info_response_builder_tb;
	import dirb_pkg::*;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic clk, rst, ctl_valid, uid_load, sync_load, ldsi_load, out_ready, cmpl_valid, cmpl_ok;
	logic out_valid, out_last, reject, slow;
	logic [7:0] ctl_code, sync_v, ldsi_id, ldsi_val, out_data, sync_o, gate_o, sync_m, gate_m;
	logic [63:0] uid, uid_m, stat_m;
	logic [8*FMT_LEN-1:0] fmt;
	logic [8*DSI_LEN-1:0] dsi;
	logic [8*DIAG_LEN-17:0] diag;
	logic [591:0] img;
	dirb_cfg_s cfg;
	dirb_stat_s stat_set;
	int n_fail = 0;
	int checked = 0;

	dirb_core u_dirb_core (.CLK_I(clk), .SYS_RST_I(rst), .CFG_I(cfg), .CTL_VALID_I(ctl_valid),
		.CTL_CODE_I(ctl_code), .UID_LOAD_I(uid_load), .UID_I(uid), .SYNC_LOAD_I(sync_load),
		.SYNC_I(sync_v), .LDSI_LOAD_I(ldsi_load), .LDSI_ID_I(ldsi_id), .LDSI_VAL_I(ldsi_val),
		.FMT_I(fmt), .DSI_I(dsi), .DIAG_I(diag), .STAT_SET_I(stat_set), .OUT_READY_I(out_ready),
		.CMPL_VALID_I(cmpl_valid), .CMPL_OK_I(cmpl_ok), .OUT_VALID_O(out_valid),
		.OUT_DATA_O(out_data), .OUT_LAST_O(out_last), .REJECT_O(reject), .SYNC_O(sync_o),
		.GATE_O(gate_o));

	dirb_ctl_model u_dirb_ctl_model (.CLK_I(clk), .slow_i(slow), .valid_i(out_valid),
		.data_i(out_data), .last_i(out_last), .ready_o(out_ready));

	// The clock runs at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	// Compare one value and count the outcome.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hold reset for eight cycles and return the model to its reset state.
	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		uid_m = cfg.card_serial;
		sync_m = SYNC_RESET;
		gate_m = GATE_RESET;
		stat_m = '0;
		@(negedge clk);
	endtask

	// Issue one control code and wait, bounded, for its final octet.
	task automatic request(input logic [7:0] code);
		int i;
		u_dirb_ctl_model.rx_q.delete();
		@(posedge clk);
		ctl_valid <= 1'b1;
		ctl_code <= code;
		@(posedge clk);
		ctl_valid <= 1'b0;
		for (i = 0; i < 4000; i++) begin
			@(negedge clk);
			if (u_dirb_ctl_model.rx_q.size() > 0 && u_dirb_ctl_model.rx_q[$][8]) break;
		end
		if (i == 4000) begin
			n_fail++;
			final_report();
		end
	endtask

	// Compare the octets taken with the low n octets of the image, first octet highest.
	task automatic cmp(input int n);
		int i;
		check(u_dirb_ctl_model.rx_q.size(), n);
		for (i = 0; i < n; i++) begin
			check(u_dirb_ctl_model.rx_q[i], {(i == n - 1), img[8 * (n - 1 - i) +: 8]});
		end
	endtask

	// Read the configuration response and compare it with the model.
	task automatic read_cfg;
		logic [31:0] turn;
		request(CODE_CONFIG);
		img = {16'(74 - 2), DEV_CLASS_DISK, cfg.drive_type, cfg.capability, cfg.feature,
			cfg.last_cyl, cfg.defect_cyl, cfg.heads, cfg.fixed_sectored ? cfg.sectors : 16'hffff,
			cfg.octets_track, cfg.seek_single, cfg.seek_avg, cfg.seek_max, cfg.rotation,
			cfg.head_switch, cfg.wr_recovery, cfg.maker, cfg.model, cfg.revision, uid_m,
			cfg.switches, sync_m, gate_m};
		cmp(74);
		// The controller derives its turnaround delay from the recovery octets 2a to 2d.
		turn = {u_dirb_ctl_model.rx_q[42][7:0], u_dirb_ctl_model.rx_q[43][7:0],
			u_dirb_ctl_model.rx_q[44][7:0], u_dirb_ctl_model.rx_q[45][7:0]};
		check(turn, cfg.wr_recovery);
	endtask

	// Raise status events, read status, then return a completion status.
	task automatic read_stat(input logic [63:0] ev, input logic ok);
		int n;
		@(posedge clk);
		stat_set <= ev;
		@(posedge clk);
		stat_set <= '0;
		stat_m |= ev;
		repeat (2) @(posedge clk);
		n = 8;
		while (n > 1 && stat_m[8 * (8 - n) +: 8] == 8'h00) n--;
		img = stat_m >> (8 * (8 - n));
		request(CODE_STATUS);
		cmp(n);
		@(posedge clk);
		cmpl_valid <= 1'b1;
		cmpl_ok <= ok;
		@(posedge clk);
		cmpl_valid <= 1'b0;
		if (ok) stat_m = '0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] bad[5];
		logic [3:0] r;
		logic v;
		int i;
		void'($urandom(32'hcb765f73));
		{rst, ctl_valid, uid_load, sync_load, ldsi_load, cmpl_valid, cmpl_ok, slow} = 8'hff;
		{ctl_valid, uid_load, sync_load, ldsi_load, cmpl_valid, cmpl_ok, slow} = 7'h00;
		{ctl_code, sync_v, ldsi_id, ldsi_val, uid} = '0;
		stat_set = '0;
		for (i = 0; i < $bits(cfg); i++) cfg[i] = 1'($urandom);
		for (i = 0; i < $bits(fmt); i++) fmt[i] = 1'($urandom);
		for (i = 0; i < $bits(dsi); i++) dsi[i] = 1'($urandom);
		for (i = 0; i < $bits(diag); i++) diag[i] = 1'($urandom);
		do_reset();
		check(sync_o, SYNC_RESET);
		check(gate_o, GATE_RESET);
		// Configuration with and without fixed sectors, fast and slow controller.
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			cfg.fixed_sectored <= 1'(i);
			slow <= 1'(i);
			read_cfg();
		end
		$display("test config done");
		// Load unit id, sync octet and gate delay; a foreign identifier must not move the gate.
		uid_m = {$urandom, $urandom} | 64'h1;
		sync_m = 8'($urandom);
		gate_m = 8'($urandom);
		@(posedge clk);
		uid_load <= 1'b1;
		uid <= uid_m;
		sync_load <= 1'b1;
		sync_v <= sync_m;
		ldsi_load <= 1'b1;
		ldsi_id <= LDSI_GATE_ID;
		ldsi_val <= gate_m;
		@(posedge clk);
		uid_load <= 1'b0;
		sync_load <= 1'b0;
		ldsi_id <= 8'h02;
		ldsi_val <= ~gate_m;
		@(posedge clk);
		ldsi_load <= 1'b0;
		repeat (2) @(negedge clk);
		check(sync_o, sync_m);
		check(gate_o, gate_m);
		read_cfg();
		$display("test loads done");
		// Format, drive specific and diagnostic responses.
		request(CODE_FORMAT);
		img = {16'(18 - 2), fmt};
		cmp(18);
		request(CODE_DRVINFO);
		img = {16'(10 - 2), dsi};
		cmp(10);
		request(CODE_DIAG);
		img = {16'(30 - 2), diag};
		cmp(30);
		$display("test responses done");
		// Status with early ending, failed and successful completions.
		read_stat(64'h8000_0000_0000_0000, 1'b0);
		read_stat(64'h0000_0000_0000_0100, 1'b1);
		read_stat({$urandom, $urandom}, 1'b0);
		read_stat(64'h0, 1'b1);
		read_stat(64'h0, 1'b1);
		$display("test status done");
		// Unknown control codes, issued only while idle, are refused without octets.
		bad = '{8'h00, 8'h40, 8'h45, 8'h48, 8'hff};
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			ctl_valid <= 1'b1;
			ctl_code <= bad[i];
			@(posedge clk);
			ctl_valid <= 1'b0;
			r = 4'h0;
			v = 1'b0;
			repeat (6) begin
				@(negedge clk);
				r = r + 4'(reject);
				v = v | out_valid;
			end
			check(r, 4'h1);
			check(v, 1'b0);
		end
		$display("test reject done");
		// A second reset restores the defaults in mid-run.
		do_reset();
		read_cfg();
		$display("test second reset done");
		final_report();
	end
endmodule // drive_info_response_builder_tb
